// [hw/irq_pkg.sv]
// constants shared by the interrupt controller and its tick timer
// assumes one system clock; all numbers of the block live here
package irq_pkg;
  localparam int IRQ_COUNT = 32;
  localparam int PRIO_W = 2;
  localparam int PRIO_FIELD_W = 8;
  localparam int PRIO_FIELD_MSB = 6;
  localparam int PRIO_PER_REG = 4;
  localparam int PRIO_REG_COUNT = IRQ_COUNT / PRIO_PER_REG;
  localparam int PRIO_IDX_W = 3;
  localparam int TICK_W = 24;
  localparam int VEC_W = 6;
  localparam int LVL_W = 3;
  // entry slots: 0..31 irqs, then the system exceptions
  localparam int SRC_COUNT = 37;
  localparam int IDX_W = 6;
  localparam logic [IDX_W-1:0] SRC_SVC = 6'h20;
  localparam logic [IDX_W-1:0] SRC_PENDABLE_SERVICE_EXC = 6'h21;
  localparam logic [IDX_W-1:0] SRC_TICK = 6'h22;
  localparam logic [IDX_W-1:0] SRC_HARD = 6'h23;
  localparam logic [IDX_W-1:0] SRC_NMI = 6'h24;
  // urgency levels: lower is more urgent, 7 means thread code
  localparam logic [LVL_W-1:0] LVL_RESET = 3'h0;
  localparam logic [LVL_W-1:0] LVL_NMI = 3'h1;
  localparam logic [LVL_W-1:0] LVL_HARD = 3'h2;
  localparam logic [LVL_W-1:0] LVL_CFG_BASE = 3'h3;
  localparam logic [LVL_W-1:0] LVL_THREAD = 3'h7;
  localparam logic [VEC_W-1:0] VEC_RESET = 6'h01;
  localparam logic [VEC_W-1:0] VEC_NMI = 6'h02;
  localparam logic [VEC_W-1:0] VEC_HARD = 6'h03;
  localparam logic [VEC_W-1:0] VEC_SVC = 6'h0B;
  localparam logic [VEC_W-1:0] VEC_PENDABLE_SERVICE_EXC = 6'h0E;
  localparam logic [VEC_W-1:0] VEC_TICK = 6'h0F;
  localparam logic [VEC_W-1:0] VEC_IRQ_BASE = 6'h10;
  localparam logic [IRQ_COUNT-1:0] IRQ_RESERVED = 32'h0B73_0000;
  localparam logic [TICK_W-1:0] TICK_ZERO = 24'h00_0000;
  localparam logic [TICK_W-1:0] TICK_ONE = 24'h00_0001;

  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_THREAD = 3'b001,
    ST_ENTRY = 3'b010,
    ST_CHAIN = 3'b011,
    ST_HANDLER = 3'b100,
    ST_DECIDE = 3'b101,
    ST_EXIT = 3'b110
  } exc_state_t;

  function automatic logic [VEC_W-1:0] vec_of(input logic [IDX_W-1:0] idx);
    logic [VEC_W-1:0] v;
    v = VEC_IRQ_BASE + idx;
    if (idx == SRC_SVC) v = VEC_SVC;
    if (idx == SRC_PENDABLE_SERVICE_EXC) v = VEC_PENDABLE_SERVICE_EXC;
    if (idx == SRC_TICK) v = VEC_TICK;
    if (idx == SRC_HARD) v = VEC_HARD;
    if (idx == SRC_NMI) v = VEC_NMI;
    return v;
  endfunction
endpackage

// [hw/nested_irq_ctrl.sv]
// nested vectored interrupt controller with its tick timer
// the core answers step_done after stacking+fetch, chain fetch or unstack
`timescale 1ns/100ps
module nested_irq_ctrl
  import irq_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic brownout_irq,
  input wire logic watchdog_irq,
  input wire logic ext_pin0_irq,
  input wire logic ext_pin1_irq,
  input wire logic gpio_group1_irq,
  input wire logic gpio_group2_irq,
  input wire logic pulse_group_a_irq,
  input wire logic pulse_group_b_irq,
  input wire logic timer0_irq,
  input wire logic timer1_irq,
  input wire logic timer2_irq,
  input wire logic timer3_irq,
  input wire logic serial_port0_2_irq,
  input wire logic serial_port1_irq,
  input wire logic sync_serial0_irq,
  input wire logic sync_serial1_irq,
  input wire logic twowire_bus0_irq,
  input wire logic twowire_bus1_irq,
  input wire logic usb_device_irq,
  input wire logic dma_irq,
  input wire logic powerdown_wakeup_irq,
  input wire logic adc_irq,
  input wire logic osc_trim_irq,
  input wire logic rtc_irq,
  input wire logic nmi_req,
  input wire logic hard_fault_req,
  input wire logic supervisor_call_req,
  input wire logic pendable_service_set,
  input wire logic pendable_service_clear,
  input wire logic [PRIO_W-1:0] supervisor_call_prio,
  input wire logic [PRIO_W-1:0] pendable_service_prio,
  input wire logic [PRIO_W-1:0] tick_timer_prio,
  input wire logic set_enable_wr,
  input wire logic clear_enable_wr,
  input wire logic set_pending_wr,
  input wire logic clear_pending_wr,
  input wire logic [IRQ_COUNT-1:0] irq_wr_data,
  input wire logic prio_wr,
  input wire logic [PRIO_IDX_W-1:0] prio_wr_index,
  input wire logic [IRQ_COUNT-1:0] prio_wr_data,
  input wire logic [PRIO_IDX_W-1:0] prio_rd_index,
  input wire logic tick_timer_enable,
  input wire logic tick_count_strobe,
  input wire logic [TICK_W-1:0] tick_reload_value,
  input wire logic tick_current_value_wr,
  input wire logic tick_status_read,
  input wire logic step_done,
  input wire logic exc_return,
  output logic [IRQ_COUNT-1:0] enable_state,
  output logic [IRQ_COUNT-1:0] pending_state,
  output logic [IRQ_COUNT-1:0] prio_rd_data,
  output logic [TICK_W-1:0] tick_current_value,
  output logic count_reached_flag,
  output logic [VEC_W-1:0] vector_num,
  output logic [VEC_W+1:0] vector_addr,
  output logic vector_fetch,
  output logic stack_push,
  output logic stack_pop,
  output logic handler_mode
);
  exc_state_t state_reg;
  logic [IRQ_COUNT-1:0] lines;
  logic [IRQ_COUNT-1:0] en_reg;
  logic [SRC_COUNT-1:0] pend_reg;
  logic [SRC_COUNT-1:0] active_reg;
  logic [PRIO_W-1:0] prio_reg [IRQ_COUNT];
  logic [SRC_COUNT*LVL_W-1:0] levels;
  logic [SRC_COUNT-1:0] eligible;
  logic cand_found;
  logic [IDX_W-1:0] cand_idx;
  logic [LVL_W-1:0] cand_level;
  logic run_found;
  logic [IDX_W-1:0] run_idx;
  logic [LVL_W-1:0] run_level;
  logic [IDX_W-1:0] lat_idx_reg;
  logic [LVL_W-1:0] lat_level_reg;
  logic tick_wrap;
  logic take;
  logic late;
  logic commit;

  // line order; reserved slots stay tied low
  assign lines = {rtc_irq, osc_trim_irq, adc_irq, powerdown_wakeup_irq, 1'b0,
    dma_irq, 2'b00, usb_device_irq, 3'b000, twowire_bus1_irq, twowire_bus0_irq,
    2'b00, sync_serial1_irq, sync_serial0_irq, serial_port1_irq, serial_port0_2_irq,
    timer3_irq, timer2_irq, timer1_irq, timer0_irq, pulse_group_b_irq,
    pulse_group_a_irq, gpio_group2_irq, gpio_group1_irq, ext_pin1_irq, ext_pin0_irq,
    watchdog_irq, brownout_irq};

  tick_timer u_tick (
    .clk(clk),
    .srst(srst),
    .enable(tick_timer_enable),
    .count_strobe(tick_count_strobe),
    .reload_value(tick_reload_value),
    .cv_write(tick_current_value_wr),
    .status_read(tick_status_read),
    .current_value(tick_current_value),
    .count_reached_flag(count_reached_flag),
    .wrap_event(tick_wrap)
  );

  // configurable levels sit under the three fixed ones
  genvar g;
  generate
    for (g = 0; g < IRQ_COUNT; g++) begin : g_irq
      assign levels[g*LVL_W +: LVL_W] = LVL_CFG_BASE + LVL_W'(prio_reg[g]);
      assign eligible[g] = pend_reg[g] && en_reg[g] && !active_reg[g];
      always_ff @(posedge clk) begin
        if (srst) begin
          prio_reg[g] <= '0;
        end else if (prio_wr && prio_wr_index == PRIO_IDX_W'(g / PRIO_PER_REG)) begin
          prio_reg[g] <= prio_wr_data[(g % PRIO_PER_REG)*PRIO_FIELD_W + PRIO_FIELD_MSB
            +: PRIO_W];
        end
      end
    end
  endgenerate
  assign levels[SRC_SVC*LVL_W +: LVL_W] = LVL_CFG_BASE + LVL_W'(supervisor_call_prio);
  assign levels[SRC_PENDABLE_SERVICE_EXC*LVL_W +: LVL_W] = LVL_CFG_BASE + LVL_W'(pendable_service_prio);
  assign levels[SRC_TICK*LVL_W +: LVL_W] = LVL_CFG_BASE + LVL_W'(tick_timer_prio);
  assign levels[SRC_HARD*LVL_W +: LVL_W] = LVL_HARD;
  assign levels[SRC_NMI*LVL_W +: LVL_W] = LVL_NMI;
  assign eligible[SRC_COUNT-1:IRQ_COUNT] = pend_reg[SRC_COUNT-1:IRQ_COUNT]
    & ~active_reg[SRC_COUNT-1:IRQ_COUNT];

  prio_resolver #(.N(SRC_COUNT)) u_pick (
    .req(eligible),
    .levels(levels),
    .found(cand_found),
    .best_idx(cand_idx),
    .best_level(cand_level)
  );

  prio_resolver #(.N(SRC_COUNT)) u_run (
    .req(active_reg),
    .levels(levels),
    .found(run_found),
    .best_idx(run_idx),
    .best_level(run_level)
  );

  // strictly more urgent than what runs now, equal never preempts
  assign take = cand_found && cand_level < run_level;
  assign late = take && cand_level < lat_level_reg;
  assign commit = step_done && (state_reg == ST_ENTRY || state_reg == ST_CHAIN);

  always_ff @(posedge clk) begin
    if (srst) begin
      en_reg <= '0;
    end else begin
      en_reg <= (en_reg | (set_enable_wr ? irq_wr_data : '0))
        & ~(clear_enable_wr ? irq_wr_data : '0) & ~IRQ_RESERVED;
    end
  end
  assign enable_state = en_reg;

  // hardware set wins over software clear and over acceptance
  logic [SRC_COUNT-1:0] pend_set;
  logic [SRC_COUNT-1:0] pend_clr;
  always_comb begin
    pend_set = '0;
    pend_clr = '0;
    pend_set[IRQ_COUNT-1:0] = (lines | (set_pending_wr ? irq_wr_data : '0))
      & ~IRQ_RESERVED;
    pend_set[SRC_SVC] = supervisor_call_req;
    pend_set[SRC_PENDABLE_SERVICE_EXC] = pendable_service_set;
    pend_set[SRC_TICK] = tick_wrap;
    pend_set[SRC_HARD] = hard_fault_req;
    pend_set[SRC_NMI] = nmi_req;
    pend_clr[IRQ_COUNT-1:0] = clear_pending_wr ? irq_wr_data : '0;
    pend_clr[SRC_PENDABLE_SERVICE_EXC] = pendable_service_clear;
    if (commit) begin
      pend_clr[lat_idx_reg] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pend_reg <= '0;
    end else begin
      pend_reg <= (pend_reg & ~pend_clr) | pend_set;
    end
  end
  assign pending_state = pend_reg[IRQ_COUNT-1:0];

  // active holds until its own return, even if disabled meanwhile
  always_ff @(posedge clk) begin
    if (srst) begin
      active_reg <= '0;
    end else if (commit) begin
      active_reg[lat_idx_reg] <= 1'b1;
    end else if (state_reg == ST_HANDLER && exc_return && !take) begin
      active_reg[run_idx] <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      prio_rd_data <= '0;
    end else begin
      for (int i = 0; i < PRIO_PER_REG; i++) begin
        prio_rd_data[i*PRIO_FIELD_W +: PRIO_FIELD_W] <= {prio_reg[
          PRIO_PER_REG*prio_rd_index + PRIO_IDX_W'(i)],
          (PRIO_FIELD_W-PRIO_W)'(0)};
      end
    end
  end

  // latched winner; a more urgent newcomer during entry or chain replaces it at once unless step_done
  always_ff @(posedge clk) begin
    if (srst) begin
      lat_idx_reg <= '0;
      lat_level_reg <= LVL_RESET;
    end else if (state_reg == ST_THREAD || state_reg == ST_HANDLER
        || state_reg == ST_DECIDE) begin
      lat_idx_reg <= cand_idx;
      lat_level_reg <= cand_level;
    end else if ((state_reg == ST_ENTRY || state_reg == ST_CHAIN) && late && !step_done) begin
      lat_idx_reg <= cand_idx;
      lat_level_reg <= cand_level;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_RESET;
    end else begin
      unique case (state_reg)
        ST_RESET: if (step_done) state_reg <= ST_THREAD;
        ST_THREAD: if (take) state_reg <= ST_ENTRY;
        ST_ENTRY, ST_CHAIN: if (step_done) state_reg <= ST_HANDLER;
        ST_HANDLER: begin
          if (take) begin
            state_reg <= ST_ENTRY;
          end else if (exc_return) begin
            state_reg <= ST_DECIDE;
          end
        end
        ST_DECIDE: state_reg <= take ? ST_CHAIN : ST_EXIT;
        ST_EXIT: if (step_done) state_reg <= run_found ? ST_HANDLER : ST_THREAD;
        default: state_reg <= ST_RESET;
      endcase
    end
  end

  // reset vector first; afterwards the latched winner's table entry
  always_ff @(posedge clk) begin
    if (srst) begin
      vector_num <= VEC_RESET;
      handler_mode <= 1'b0;
    end else begin
      if (state_reg == ST_ENTRY || state_reg == ST_CHAIN || state_reg == ST_RESET) begin
        vector_num <= state_reg == ST_RESET ? VEC_RESET : vec_of(lat_idx_reg);
      end
      if (commit) begin
        handler_mode <= 1'b1;
      end else if (state_reg == ST_EXIT && step_done && !run_found) begin
        handler_mode <= 1'b0;
      end
    end
  end

  assign vector_addr = {vector_num, 2'b00};
  assign vector_fetch = state_reg == ST_ENTRY || state_reg == ST_CHAIN
    || state_reg == ST_RESET;
  assign stack_push = state_reg == ST_ENTRY;
  assign stack_pop = state_reg == ST_EXIT;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_reserved_quiet: assert property ((pend_reg[IRQ_COUNT-1:0] & IRQ_RESERVED) == '0)
    else $error("reserved line pending");
  a_equal_no_preempt: assert property (state_reg == ST_HANDLER && cand_found
    && cand_level >= run_level |=> state_reg != ST_ENTRY) else $error("equal preempted");
  a_vector_match: assert property (state_reg == ST_ENTRY && !late |=>
    vector_num == vec_of($past(lat_idx_reg))) else $error("wrong vector");
  a_late_switch: assert property (state_reg == ST_ENTRY && late && !step_done
    |=> lat_idx_reg == $past(cand_idx) && state_reg == ST_ENTRY) else $error("late lost");
  a_chain_no_stack: assert property (state_reg == ST_DECIDE && take
    |=> vector_fetch && !stack_push && !stack_pop) else $error("chain stacked");
  a_handler_mode: assert property (commit
    |=> handler_mode && active_reg[$past(lat_idx_reg)]) else $error("not handler mode");
  a_disabled_idle: assert property (commit && lat_idx_reg < SRC_SVC
    |-> en_reg[lat_idx_reg[4:0]]) else $error("disabled activated");
  // request pends one edge before it can be taken, so watch the pending bit
  a_fixed_above: assert property (pend_reg[SRC_NMI] && state_reg == ST_THREAD
    |=> state_reg == ST_ENTRY && lat_level_reg == LVL_NMI) else $error("nmi not urgent");
  a_push_fetch: assert property (stack_push |-> vector_fetch)
    else $error("push without fetch");
  c_tail_chain: cover property (state_reg == ST_DECIDE ##1 state_reg == ST_CHAIN);
  c_late_arrival: cover property (state_reg == ST_ENTRY && late && !step_done);
  c_preempt: cover property (state_reg == ST_HANDLER && take);
  c_tick_entry: cover property (commit && lat_idx_reg == SRC_TICK);
endmodule // nested_irq_ctrl

// [hw/prio_resolver.sv]
// picks the most urgent requesting slot; ties go to the lowest slot
// purely combinational
`timescale 1ns/100ps
module prio_resolver
  import irq_pkg::*;
#(
  parameter int N = SRC_COUNT
) (
  input wire logic [N-1:0] req,
  input wire logic [N*LVL_W-1:0] levels,
  output logic found,
  output logic [IDX_W-1:0] best_idx,
  output logic [LVL_W-1:0] best_level
);
  always_comb begin
    found = 1'b0;
    best_idx = '0;
    best_level = LVL_THREAD;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i] && (!found || levels[i*LVL_W +: LVL_W] <= best_level)) begin
        found = 1'b1;
        best_idx = IDX_W'(i);
        best_level = levels[i*LVL_W +: LVL_W];
      end
    end
  end
endmodule // prio_resolver

// [hw/tick_timer.sv]
// 24-bit down counter with reload and sticky count-reached flag
// count_strobe marks one timer clock, already in the clk domain
`timescale 1ns/100ps
module tick_timer
  import irq_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic enable,
  input wire logic count_strobe,
  input wire logic [TICK_W-1:0] reload_value,
  input wire logic cv_write,
  input wire logic status_read,
  output logic [TICK_W-1:0] current_value,
  output logic count_reached_flag,
  output logic wrap_event
);
  logic step;
  logic hit_zero;
  assign step = enable && count_strobe && !cv_write;
  assign hit_zero = step && current_value == TICK_ONE;
  assign wrap_event = hit_zero;

  // value after reset is left to software, cleared here for determinism
  always_ff @(posedge clk) begin
    if (srst) begin
      current_value <= TICK_ZERO;
    end else if (cv_write) begin
      current_value <= TICK_ZERO;
    end else if (step) begin
      if (current_value == TICK_ZERO) begin
        current_value <= reload_value;
      end else begin
        current_value <= current_value - TICK_ONE;
      end
    end
  end

  // set beats the read-clear in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      count_reached_flag <= 1'b0;
    end else if (hit_zero) begin
      count_reached_flag <= 1'b1;
    end else if (status_read) begin
      count_reached_flag <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_tick_decrement: assert property (step && current_value != TICK_ZERO
    |=> current_value == $past(current_value) - TICK_ONE) else $error("no decrement");
  a_tick_reload: assert property (step && current_value == TICK_ZERO
    |=> current_value == $past(reload_value)) else $error("no reload");
  a_flag_set: assert property (hit_zero |=> count_reached_flag ##1
    (count_reached_flag || $past(status_read))) else $error("flag lost");
  a_flag_read_clear: assert property (status_read && !hit_zero
    |=> !count_reached_flag) else $error("flag not cleared by read");
  a_cv_write_clear: assert property (cv_write |=> current_value == TICK_ZERO)
    else $error("write did not clear");
  a_zero_reload_hold: assert property (reload_value == TICK_ZERO
    && current_value == TICK_ZERO |=> current_value == TICK_ZERO) else $error("hold lost");
endmodule // tick_timer

// [verif/core_model.sv]
// core-side partner: answers every fetch, push or pop step, then runs each handler
// assumes the controller holds a step request until it sees step_done
`timescale 1ns/100ps
module core_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic busy,
  input wire logic handler_mode,
  input wire logic [3:0] step_delay,
  input wire logic [7:0] handler_len,
  output logic step_done,
  output logic exc_return
);
  logic [3:0] wait_reg;
  logic [7:0] run_reg;
  // fresh wait per step, so a slow core stays slow on every step
  always_ff @(posedge clk) begin
    if (srst || step_done || !busy) begin
      step_done <= 1'b0;
      wait_reg <= 4'h0;
    end else if (wait_reg >= step_delay) begin
      step_done <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
  // handler_len must exceed 0 so the decide cycle cannot return twice
  always_ff @(posedge clk) begin
    if (srst || exc_return || busy || !handler_mode) begin
      exc_return <= 1'b0;
      run_reg <= 8'h00;
    end else if (run_reg >= handler_len) begin
      exc_return <= 1'b1;
    end else begin
      run_reg <= run_reg + 8'h01;
    end
  end
endmodule // core_model

// [verif/test_nested_irq_ctrl.sv]
// bench for nested_irq_ctrl with an integer reference model
// inputs change on the falling edge; core_model plays the core
`timescale 1ns/100ps
module test_nested_irq_ctrl
  import irq_pkg::*;
;
  logic clk, srst, nmi, hfr, svc, pss, psc, sew, cew, spw, cpw, pw, ten, tst, tcw, trd;
  logic sdone, eret, flag, vfe, push, pop, hm;
  logic [1:0] svp, psp, tkp;
  logic [2:0] pidx, ridx;
  logic [3:0] sdly;
  logic [5:0] vnum;
  logic [7:0] hlen, vadr;
  logic [23:0] trel, tcv;
  logic [31:0] lines, wd, pd, ens, pns, prd, rnd, exp_en, exp_pn;
  int n_mismatch, samples_checked, k, op, ecv, pops, seen;
  int vecs[4] = '{2, 3, 11, 14};
  integer seed;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  nested_irq_ctrl nested_irq_ctrl_i (
    .clk(clk), .srst(srst), .brownout_irq(lines[0]), .watchdog_irq(lines[1]),
    .ext_pin0_irq(lines[2]), .ext_pin1_irq(lines[3]), .gpio_group1_irq(lines[4]),
    .gpio_group2_irq(lines[5]), .pulse_group_a_irq(lines[6]), .pulse_group_b_irq(lines[7]),
    .timer0_irq(lines[8]), .timer1_irq(lines[9]), .timer2_irq(lines[10]),
    .timer3_irq(lines[11]), .serial_port0_2_irq(lines[12]), .serial_port1_irq(lines[13]),
    .sync_serial0_irq(lines[14]), .sync_serial1_irq(lines[15]),
    .twowire_bus0_irq(lines[18]), .twowire_bus1_irq(lines[19]), .usb_device_irq(lines[23]),
    .dma_irq(lines[26]), .powerdown_wakeup_irq(lines[28]), .adc_irq(lines[29]),
    .osc_trim_irq(lines[30]), .rtc_irq(lines[31]), .nmi_req(nmi), .hard_fault_req(hfr),
    .supervisor_call_req(svc), .pendable_service_set(pss), .pendable_service_clear(psc),
    .supervisor_call_prio(svp), .pendable_service_prio(psp), .tick_timer_prio(tkp),
    .set_enable_wr(sew), .clear_enable_wr(cew), .set_pending_wr(spw),
    .clear_pending_wr(cpw), .irq_wr_data(wd), .prio_wr(pw), .prio_wr_index(pidx),
    .prio_wr_data(pd), .prio_rd_index(ridx), .tick_timer_enable(ten),
    .tick_count_strobe(tst), .tick_reload_value(trel), .tick_current_value_wr(tcw),
    .tick_status_read(trd), .step_done(sdone), .exc_return(eret), .enable_state(ens),
    .pending_state(pns), .prio_rd_data(prd), .tick_current_value(tcv),
    .count_reached_flag(flag), .vector_num(vnum), .vector_addr(vadr), .vector_fetch(vfe),
    .stack_push(push), .stack_pop(pop), .handler_mode(hm));
  core_model core_model_i (.clk(clk), .srst(srst), .busy(vfe | push | pop),
    .handler_mode(hm), .step_delay(sdly), .handler_len(hlen), .step_done(sdone),
    .exc_return(eret));
  always @(posedge pop) pops++;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // 0 push, 1 handler, 2 idle, 100+v vector v
  task automatic wait_on(input int w);
    int i;
    for (i = 0; i < 900; i++) begin
      // handler mode may already stand from a preempted handler: wait for push to drop
      if ((w == 0 && push === 1'b1) || (w == 1 && hm === 1'b1 && push === 1'b0)) break;
      if ((w == 2 && {hm, vfe, push, pop} === 4'h0) || (w > 99 && vnum === 6'(w - 100))) break;
      @(negedge clk);
    end
    if (i == 900) begin
      chk("wait", w, -1);
      end_sim();
    end
  endtask
  task automatic entry(input int v);
    wait_on(0);
    @(negedge clk);
    chk("vector_num", v, vnum);
    chk("vector_addr", v * 4, vadr);
    chk("fetch_with_push", 1, vfe);
    wait_on(1);
    chk("entry_done", 0, {vfe, push});
  endtask
  // one-cycle pulse, so a held level cannot re-pend
  task automatic pulse(input int n);
    lines[n] = 1'b1;
    @(negedge clk);
    lines[n] = 1'b0;
  endtask
  task automatic wr(input int o, input logic [31:0] d);
    wd = d;
    {sew, cew, spw, cpw} = 4'h8 >> o;
    @(negedge clk);
    {sew, cew, spw, cpw} = 4'h0;
    @(negedge clk);
  endtask
  task automatic pwr(input int i, input logic [31:0] d);
    pidx = 3'(i);
    pd = d;
    pw = 1'b1;
    @(negedge clk);
    pw = 1'b0;
    ridx = 3'(i);
    repeat (2) @(negedge clk);
  endtask
  initial begin
    seed = 32'hb49e_ab1a;
    {nmi, hfr, svc, pss, psc, sew, cew, spw, cpw, pw, ten, tst, tcw, trd} = 14'h0;
    {svp, psp, tkp, pidx, ridx, sdly, hlen} = 24'h00_0004;
    {lines, wd, pd, trel, exp_en, exp_pn} = '0;
    srst = 1'b1;
    repeat (6) @(negedge clk);
    chk("state_rst", 0, ens | pns);
    chk("tick_rst", 0, {tcv, flag});
    chk("vec_rst", 32'h0000_0041, {hm, vfe, vnum});
    srst = 1'b0;
    wait_on(2);
    for (k = 0; k < 8; k++) begin
      ridx = 3'(k);
      repeat (2) @(negedge clk);
      chk("prio_rst", 0, prd & 32'hC0C0_C0C0);
      rnd = $random(seed);
      pwr(k, rnd);
      chk("prio_word", rnd & 32'hC0C0_C0C0, prd & 32'hC0C0_C0C0);
    end
    $display("test registers done");
    for (k = 0; k < 16; k++) begin
      if (k == 8) begin
        wr(3, 32'hFFFF_FFFF);
        exp_pn = '0;
      end
      rnd = $random(seed);
      op = k < 8 ? 2 + k % 2 : k % 2;
      wr(op, rnd);
      if (op == 0) exp_en |= rnd & ~IRQ_RESERVED;
      if (op == 1) exp_en &= ~rnd;
      if (op == 2) exp_pn |= rnd & ~IRQ_RESERVED;
      if (op == 3) exp_pn &= ~rnd;
      chk("enable_state", exp_en, ens);
      chk("pending_state", exp_pn, pns);
    end
    wr(0, 32'hFFFF_FFFF);
    pops = 0;
    seen = 0;
    for (k = 0; k < 32; k++) begin
      if (IRQ_RESERVED[k] == 1'b0) begin
        pulse(k);
        entry(16 + k);
        wait_on(2);
        seen++;
      end
    end
    chk("pop_count", seen, pops);
    for (k = 0; k < 4; k++) begin
      {nmi, hfr, svc, pss} = 4'h8 >> k;
      @(negedge clk);
      {nmi, hfr, svc, pss} = 4'h0;
      entry(vecs[k]);
      wait_on(2);
    end
    $display("test vectors done");
    hlen = 8'h3C;
    pwr(2, 32'h00C0_8080);
    pwr(3, 32'h0000_0040);
    pulse(8);
    entry(24);
    pulse(9);
    repeat (6) @(negedge clk);
    chk("equal_no_preempt", 2, {pns[9], push});
    pulse(12);
    entry(28);
    pops = 0;
    nmi = 1'b1;
    @(negedge clk);
    nmi = 1'b0;
    entry(2);
    wait_on(125);
    chk("chain_pops", 2, pops + pop);
    wait_on(2);
    sdly = 4'h8;
    hlen = 8'h04;
    pulse(10);
    wait_on(0);
    pulse(11);
    wait_on(127);
    chk("late_arrival", 2, {push, hm});
    wait_on(2);
    $display("test nesting done");
    sdly = 4'h0;
    trel = 24'h00_0005;
    ten = 1'b1;
    tst = 1'b1;
    ecv = 0;
    seen = 0;
    for (k = 0; k < 40; k++) begin
      if (k == 24) trel = 24'h00_0000;
      tcw = k == 0 || k == 9;
      @(negedge clk);
      ecv = tcw ? 0 : ecv == 0 ? int'(trel) : ecv - 1;
      seen |= vnum === VEC_TICK;
      chk("tick_value", ecv, tcv);
    end
    tcw = 1'b0;
    tst = 1'b0;
    chk("tick_vector", 1, seen);
    chk("flag_set", 1, flag);
    trd = 1'b1;
    @(negedge clk);
    trd = 1'b0;
    @(negedge clk);
    chk("flag_read", 0, flag);
    wait_on(2);
    $display("test tick done");
    end_sim();
  end
endmodule // test_nested_irq_ctrl
